// ### design/rcs_command_status.sv
/*
  Remote command and error status block. Holds the command control word
  in the shared data file, decodes write-back / warm / cold boot
  requests, and keeps one status word per command-list entry.
  Assumes a single-master word port into the shared file, a command
  engine that reports each completion as a one-cycle record, and a host
  side that services the configuration write-back request.
*/
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_command_status
  import rcs_pkg::*;
(
  input wire logic clk_i, // 50 MHz clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic [15:0] addr_i, // Shared file word address
  input wire logic wr_i, // Word write strobe
  input wire logic [15:0] wdata_i, // Write data
  input wire logic rd_i, // Word read strobe
  output logic [15:0] rdata_o, // Read data, one cycle after rd_i
  output logic rvalid_o, // Read data valid pulse
  output logic cfg_req_o, // Write-back request to host, level
  input wire logic cfg_done_i, // Host finished write-back, pulse
  input wire logic cfg_ok_i, // Write-back succeeded, with done
  output logic warm_boot_o, // Warm boot pulse
  output logic cold_boot_o, // Cold boot pulse
  input wire logic res_valid_i, // Command completion pulse
  input wire logic [3:0] res_idx_i, // Command-list entry index
  input wire rcs_result_s res_i // Completion record
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [15:0] ctrl_word;
  logic [15:0] stat_mem [`RCS_STAT_DEPTH];
  rcs_state_e state;
  rcs_state_e next_state;
  logic [15:0] next_ctrl;
  logic [15:0] enc_word;

  // ------------------------------------------------------------------
  // Address decode and command decode
  // ------------------------------------------------------------------
  logic hit_ctrl;
  logic hit_stat;
  logic host_ctrl_wr;
  logic is_wrback;
  logic is_warm;
  logic is_cold;
  logic [3:0] stat_idx;
  logic [15:0] stat_base;

  // Status region starts at the base, one word per entry
  assign stat_base = `RCS_STAT_BASE;
  assign hit_ctrl = (addr_i == `RCS_CTRL_ADDR);
  assign hit_stat = (addr_i[15:4] == stat_base[15:4]);
  assign stat_idx = addr_i[3:0];
  assign host_ctrl_wr = wr_i && hit_ctrl;
  assign is_wrback = (ctrl_word == `RCS_CMD_WRBACK);
  assign is_warm = (ctrl_word == `RCS_CMD_WARM);
  assign is_cold = (ctrl_word == `RCS_CMD_COLD);

  // ------------------------------------------------------------------
  // Control word sequencing
  // ------------------------------------------------------------------
  // A host write always wins over the block's own update, so a new
  // command landing in the clearing cycle is never lost.
  logic boot_warm;
  logic boot_cold;

  always_comb
  begin
    next_state = state;
    next_ctrl = ctrl_word;
    boot_warm = 1'b0;
    boot_cold = 1'b0;
    unique case (state)
      RCS_IDLE:
      begin
        if (is_wrback)
          next_state = RCS_WAIT;
        else if (is_warm)
        begin
          boot_warm = 1'b1;
          next_ctrl = `RCS_CTRL_RESET;
        end
        else if (is_cold)
        begin
          boot_cold = 1'b1;
          next_ctrl = `RCS_CTRL_RESET;
        end
        // Any other value is simply left alone
      end
      RCS_WAIT:
      begin
        // The host must do the transfer; we only wait for it
        if (cfg_done_i)
        begin
          next_state = RCS_DONE;
          next_ctrl = cfg_ok_i ? `RCS_RES_OK : `RCS_RES_FAIL;
          boot_warm = cfg_ok_i;
        end
      end
      RCS_DONE:
        next_state = RCS_IDLE;
      default:
        next_state = RCS_IDLE;
    endcase
    if (host_ctrl_wr)
    begin
      next_ctrl = wdata_i;
      boot_warm = 1'b0;
      boot_cold = 1'b0;
      if (state == RCS_WAIT)
        next_state = RCS_IDLE;
    end
  end

  // State, control word and boot pulses
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= RCS_IDLE;
      ctrl_word <= `RCS_CTRL_RESET;
      warm_boot_o <= 1'b0;
      cold_boot_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ctrl_word <= next_ctrl;
      warm_boot_o <= boot_warm;
      cold_boot_o <= boot_cold;
    end
  end

  // Request stays up for the whole wait so the host cannot miss it
  assign cfg_req_o = (state == RCS_WAIT);

  // ------------------------------------------------------------------
  // Per-entry status words
  // ------------------------------------------------------------------
  rcs_status_enc u_enc (
    .res_i (res_i),
    .word_o (enc_word)
  );

  // Entries are written only by the block; host writes there are dropped
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < `RCS_STAT_DEPTH; i++)
        stat_mem[i] <= 16'h0000;
    end
    else if (res_valid_i)
      stat_mem[res_idx_i] <= enc_word;
  end

  // ------------------------------------------------------------------
  // Read port: registered, unmapped words read as zero
  // ------------------------------------------------------------------
  logic [15:0] rd_sel;

  assign rd_sel = hit_ctrl ? ctrl_word :
                  hit_stat ? stat_mem[stat_idx] : 16'h0000;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_i;
      if (rd_i)
        rdata_o <= rd_sel;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_wb_start;
    state == RCS_IDLE && is_wrback && !host_ctrl_wr ##1 cfg_req_o;
  endsequence

  sequence s_wb_fail;
    cfg_done_i && !cfg_ok_i && !host_ctrl_wr;
  endsequence

  a_wb_request: assert property (
    s_wb_start |-> ctrl_word == `RCS_CMD_WRBACK && !warm_boot_o)
    else $error("write-back did not start cleanly");

  a_wb_fail_code: assert property (
    state == RCS_WAIT ##0 s_wb_fail
    |=> ctrl_word == `RCS_RES_FAIL && !warm_boot_o)
    else $error("failed write-back did not return minus one");

  a_wb_ok_boot: assert property (
    state == RCS_WAIT && cfg_done_i && cfg_ok_i && !host_ctrl_wr
    |=> ctrl_word == `RCS_RES_OK && warm_boot_o && !cfg_req_o)
    else $error("successful write-back did not clear and boot");

  a_wb_no_clear: assert property (
    state == RCS_WAIT && !cfg_done_i && !host_ctrl_wr
    |=> $stable(ctrl_word))
    else $error("write-back word changed while waiting");

  a_warm_clear: assert property (
    state == RCS_IDLE && is_warm && !host_ctrl_wr
    |=> warm_boot_o && !cold_boot_o && ctrl_word == 16'h0000)
    else $error("warm boot not issued and cleared");

  a_cold_clear: assert property (
    state == RCS_IDLE && is_cold && !host_ctrl_wr
    |=> cold_boot_o && !warm_boot_o && ctrl_word == 16'h0000)
    else $error("cold boot not issued and cleared");

  a_other_kept: assert property (
    state == RCS_IDLE && !is_wrback && !is_warm && !is_cold &&
    !host_ctrl_wr |=> $stable(ctrl_word) && !warm_boot_o && !cold_boot_o
    && !cfg_req_o)
    else $error("undefined control value acted on");

  a_host_wins: assert property (
    host_ctrl_wr |=> ctrl_word == $past(wdata_i))
    else $error("host write to control word lost");

  a_stat_store: assert property (
    res_valid_i |=> stat_mem[$past(res_idx_i)] == $past(enc_word))
    else $error("status word not stored for entry");

  a_ext_layout: assert property (
    res_i.kind == RCS_K_EXT |-> enc_word == {8'hF0, res_i.ext})
    else $error("extended status not in low byte under F0");

  a_local_layout: assert property (
    res_i.kind == RCS_K_LOCAL |-> enc_word[7:0] == 8'h00 &&
    enc_word[15:8] <= 8'h08)
    else $error("local status outside its byte or table");

  a_slave_not_mod: assert property (
    res_i.kind != RCS_K_MODULE |-> enc_word[15:8] != 8'hFF)
    else $error("slave-sourced code looks module-specific");

endmodule

// ### design/rcs_defs.svh
/*
  Constants for the remote command and status block: shared-file word
  addresses, command codes, result codes and the status code tables.
  Assumes it is included by bare name from the modules and the bench.
*/
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// ------------------------------------------------------------------
// Shared data file addresses
// ------------------------------------------------------------------
`define RCS_CTRL_ADDR 16'h1E78
`define RCS_STAT_BASE 16'h1F40
`define RCS_STAT_IDX_W 4
`define RCS_STAT_DEPTH 16

// ------------------------------------------------------------------
// Control word commands and results
// ------------------------------------------------------------------
`define RCS_CMD_WRBACK 16'h270D
`define RCS_CMD_WARM 16'h270E
`define RCS_CMD_COLD 16'h270F
`define RCS_CTRL_RESET 16'h0000
`define RCS_RES_OK 16'h0000
`define RCS_RES_FAIL 16'hFFFF

// ------------------------------------------------------------------
// Status word layout and code tables
// ------------------------------------------------------------------
`define RCS_STS_MSB 15
`define RCS_STS_LSB 8
`define RCS_LOCAL_MAX 8'h08
`define RCS_LOCAL_HWFAULT 8'h08
`define RCS_REMOTE_ILLEGAL 4'h1
`define RCS_REMOTE_UNUSED0 4'hD
`define RCS_REMOTE_UNUSED1 4'hE
`define RCS_EXTENDED_STATUS_BYTE 8'hF0
`define RCS_MOD_CTS 16'hFFFF
`define RCS_MOD_TXTMO 16'hFFFE
`define RCS_MOD_ACKTMO 16'hFFF6
`define RCS_MOD_RSPTMO 16'hFFF5
`define RCS_MOD_COUNT 16'hFFF4
`define RCS_MOD_NAKRX 16'hFFEC
`define RCS_MOD_NAKTX 16'hFFEB

`endif

// ### design/rcs_pkg.sv
/*
  Types for the remote command and status block: control state machine
  states, result kinds and the completion record of one command.
  Assumes rcs_defs.svh is on the include path.
*/
package rcs_pkg;

  // Control word state machine, one-hot
  typedef enum logic [2:0] {
    RCS_IDLE = 3'b001,
    RCS_WAIT = 3'b010,
    RCS_DONE = 3'b100
  } rcs_state_e;

  // Where a completion code comes from
  typedef enum logic [1:0] {
    RCS_K_LOCAL = 2'h0,
    RCS_K_REMOTE = 2'h1,
    RCS_K_EXT = 2'h2,
    RCS_K_MODULE = 2'h3
  } rcs_kind_e;

  // Module-generated failures
  typedef enum logic [2:0] {
    RCS_M_CTS = 3'h0,
    RCS_M_TXTMO = 3'h1,
    RCS_M_ACKTMO = 3'h2,
    RCS_M_RSPTMO = 3'h3,
    RCS_M_COUNT = 3'h4,
    RCS_M_NAKRX = 3'h5,
    RCS_M_NAKTX = 3'h6
  } rcs_mod_e;

  // One command completion, as reported by the command engine
  typedef struct packed {
    rcs_kind_e kind;
    logic [7:0] code;
    logic [7:0] ext;
  } rcs_result_s;

endpackage

// ### design/rcs_status_enc.sv
/*
  Status word encoder: turns one completion record into the 16-bit word
  kept per command entry. Purely combinational.
  Assumes the record fields are valid whenever the word is sampled.
*/
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_status_enc
  import rcs_pkg::*;
(
  input wire rcs_result_s res_i, // Completion record
  output logic [15:0] word_o // Encoded status word
);

  // ------------------------------------------------------------------
  // Table lookups
  // ------------------------------------------------------------------
  logic [7:0] local_sts;
  logic [3:0] remote_nib;
  logic [15:0] module_word;
  logic remote_to_ext;

  // Out-of-table local codes collapse to hardware fault
  assign local_sts = (res_i.code > `RCS_LOCAL_MAX) ?
                     `RCS_LOCAL_HWFAULT : res_i.code;

  // Unused nibbles fall back to illegal command; 0xF needs the ext byte
  assign remote_nib = (res_i.code[7:4] == `RCS_REMOTE_UNUSED0 ||
                       res_i.code[7:4] == `RCS_REMOTE_UNUSED1) ?
                      `RCS_REMOTE_ILLEGAL : res_i.code[7:4];
  assign remote_to_ext = (res_i.code[7:4] == 4'hF);

  // Module failures are only ever built here, never passed through
  always_comb
  begin
    unique case (rcs_mod_e'(res_i.code[2:0]))
      RCS_M_CTS: module_word = `RCS_MOD_CTS;
      RCS_M_TXTMO: module_word = `RCS_MOD_TXTMO;
      RCS_M_ACKTMO: module_word = `RCS_MOD_ACKTMO;
      RCS_M_RSPTMO: module_word = `RCS_MOD_RSPTMO;
      RCS_M_COUNT: module_word = `RCS_MOD_COUNT;
      RCS_M_NAKRX: module_word = `RCS_MOD_NAKRX;
      RCS_M_NAKTX: module_word = `RCS_MOD_NAKTX;
      default: module_word = `RCS_MOD_CTS;
    endcase
  end

  // ------------------------------------------------------------------
  // Word assembly: status in the upper byte, extended in the lower
  // ------------------------------------------------------------------
  always_comb
  begin
    unique case (res_i.kind)
      RCS_K_LOCAL: word_o = {local_sts, 8'h00};
      RCS_K_REMOTE: word_o = remote_to_ext ?
                    {`RCS_EXTENDED_STATUS_BYTE, res_i.ext} :
                    {remote_nib, 12'h000};
      RCS_K_EXT: word_o = {`RCS_EXTENDED_STATUS_BYTE, res_i.ext};
      RCS_K_MODULE: word_o = module_word;
    endcase
  end

endmodule

// ### verification/rcs_host_model.sv
/*
  Host controller model: answers the write-back request with a done
  pulse and a pass or fail flag. Assumes the bench clock and reset.
*/
`timescale 1ns/1ps
module rcs_host_model
(
  input wire logic clk_i, // Bench clock
  input wire logic reset_i, // Synchronous reset
  input wire logic cfg_req_o, // Request from the block
  input wire logic ok_i, // Outcome to report
  output logic cfg_done_i, // Done pulse to the block
  output logic cfg_ok_i // Outcome, valid with done
);
  logic [1:0] wait_cnt;
  // Flag is inverted outside the done cycle so a stale value cannot pass
  assign cfg_ok_i = cfg_done_i ? ok_i : ~ok_i;
  // ----------------------------------------------------------------
  // Service the request after three cycles, one pulse only
  // ----------------------------------------------------------------
  always @(negedge clk_i)
  begin
    if (reset_i)
    begin
      wait_cnt <= 2'h0;
      cfg_done_i <= 1'b0;
    end
    else if (cfg_req_o && !cfg_done_i && wait_cnt == 2'h3)
    begin
      cfg_done_i <= 1'b1;
      wait_cnt <= 2'h0;
    end
    else
    begin
      cfg_done_i <= 1'b0;
      wait_cnt <= (cfg_req_o && !cfg_done_i) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ### verification/testbench.sv
/*
  Self-checking bench for the command and status block. Assumes the
  host model answers write-back requests; stimulus at falling edges.
*/
`timescale 1ns/1ps
`include "rcs_defs.svh"
module testbench
  import rcs_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic wr_i = 1'b0;
  logic [15:0] wdata_i = 16'h0000;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic rvalid_o, cfg_req_o, cfg_done_i, cfg_ok_i;
  logic warm_boot_o, cold_boot_o;
  logic res_valid_i = 1'b0;
  logic [3:0] res_idx_i = 4'h0;
  rcs_result_s res_i = '0;
  logic host_ok = 1'b1;
  int bad_count = 0;
  int num_checks = 0;
  int warm_n = 0;
  int cold_n = 0;
  int cycles = 0;
  rcs_result_s tv [7];
  logic [15:0] te [7];
  // ----------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------
  rcs_command_status dut (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cfg_req_o(cfg_req_o),
    .cfg_done_i(cfg_done_i), .cfg_ok_i(cfg_ok_i),
    .warm_boot_o(warm_boot_o), .cold_boot_o(cold_boot_o),
    .res_valid_i(res_valid_i), .res_idx_i(res_idx_i), .res_i(res_i));
  rcs_host_model host (.clk_i(clk_i), .reset_i(reset_i),
    .cfg_req_o(cfg_req_o), .ok_i(host_ok), .cfg_done_i(cfg_done_i),
    .cfg_ok_i(cfg_ok_i));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  // Boot pulses counted, so a stuck-high pulse shows as a bad count
  always @(posedge clk_i)
  begin
    warm_n <= warm_n + (warm_boot_o === 1'b1);
    cold_n <= cold_n + (cold_boot_o === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // Bus tasks and compare
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    wr_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk_i);
    rd_i = 1'b1;
    addr_i = a;
    @(negedge clk_i);
    // Valid stands one cycle only, so it is judged here, not later
    rd_i = 1'b0;
    chk({15'h0, rvalid_o}, 16'h1);
    chk(rdata_o, e);
  endtask
  // Boot command: pulse two edges after the write, word then cleared
  task automatic boot(input logic [15:0] c, input int w, input int k);
    int w0;
    int k0;
    w0 = warm_n;
    k0 = cold_n;
    wr(`RCS_CTRL_ADDR, c);
    repeat (3) @(negedge clk_i);
    chk(16'(warm_n - w0), 16'(w));
    chk(16'(cold_n - k0), 16'(k));
    rd_chk(`RCS_CTRL_ADDR, (w + k) ? 16'h0000 : c);
    $display("test boot %h done", c);
  endtask
  task automatic wback(input logic ok, input logic [15:0] e);
    int w0;
    int i;
    logic seen;
    w0 = warm_n;
    seen = 1'b0;
    host_ok = ok;
    wr(`RCS_CTRL_ADDR, `RCS_CMD_WRBACK);
    for (i = 0; i < 30 && !(seen && cfg_req_o === 1'b0); i++)
    begin
      @(negedge clk_i);
      if (cfg_req_o === 1'b1)
        seen = 1'b1;
    end
    chk({15'h0, seen}, 16'h1);
    repeat (2) @(negedge clk_i);
    chk(16'(warm_n - w0), {15'h0, ok});
    rd_chk(`RCS_CTRL_ADDR, e);
    $display("test write-back %b done", ok);
  endtask
  // Completions of every kind, then a host write into the status area
  task automatic status_test();
    int i;
    tv = '{'{RCS_K_LOCAL, 8'h05, 8'h00}, '{RCS_K_LOCAL, 8'h09, 8'h00},
      '{RCS_K_REMOTE, 8'h70, 8'h00}, '{RCS_K_REMOTE, 8'hD0, 8'h00},
      '{RCS_K_EXT, 8'h00, 8'h07}, '{RCS_K_MODULE, 8'h02, 8'h00},
      '{RCS_K_REMOTE, 8'hF3, 8'h21}};
    te = '{16'h0500, 16'h0800, 16'h7000, 16'h1000, 16'hF007, 16'hFFF6,
      16'hF021};
    for (i = 0; i < 7; i++)
    begin
      @(negedge clk_i);
      res_valid_i = 1'b1;
      res_idx_i = 4'(i);
      res_i = tv[i];
    end
    @(negedge clk_i);
    res_valid_i = 1'b0;
    wr(`RCS_STAT_BASE, 16'hAAAA);
    rd_chk(`RCS_STAT_BASE, te[0]);
    rd_chk(`RCS_STAT_BASE + 16'h0001, te[1]);
    rd_chk(`RCS_STAT_BASE + 16'h0002, te[2]);
    rd_chk(`RCS_STAT_BASE + 16'h0003, te[3]);
    rd_chk(`RCS_STAT_BASE + 16'h0004, te[4]);
    rd_chk(`RCS_STAT_BASE + 16'h0005, te[5]);
    rd_chk(`RCS_STAT_BASE + 16'h0006, te[6]);
    $display("test status done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    rd_chk(`RCS_CTRL_ADDR, 16'h0000);
    rd_chk(16'h0001, 16'h0000);
    boot(`RCS_CMD_WARM, 1, 0);
    boot(`RCS_CMD_COLD, 0, 1);
    boot(16'h1234, 0, 0);
    wback(1'b1, `RCS_RES_OK);
    wback(1'b0, `RCS_RES_FAIL);
    status_test();
    stop_test();
  end
endmodule
